// ### shared/inta_takeover_consts.vh
// constants for the acknowledge bus takeover block
// assumes a 50 MHz system clock and backplane inputs already on the pins
`ifndef INTA_TAKEOVER_CONSTS_VH
`define INTA_TAKEOVER_CONSTS_VH
`define CNT_W          2
`define CNT_ZERO       2'h0
`define CNT_ONE        2'h1
`define CNT_TWO        2'h2
`define CASC_W         3
`define CASC_ZERO      3'h0
`define HOLD_NS        60
`define CLK_NS         20
// status kept valid this many cycles after the cpu drops it
`define HOLD_CYC       ((`HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLD_W         2
`define HOLD_ZERO      2'h0
// sized load value for the stretch counter; keep equal to HOLD_CYC
`define HOLD_LOAD      2'h3
`define ST_IDLE        3'h1
`define ST_FIRST       3'h2
`define ST_TAKE        3'h4
`endif

// ### design/inta_bus_takeover.v
// bus takeover logic for multi-byte interrupt acknowledge sequences
// assumes backplane strobes arrive asynchronously; the cascade code comes
// from the interrupt controller on the same clock
//
// Notes on behaviour
// - later cycles: disable cpu status, drive ack status
// - also drive address, cascade code on A0-A2
// - two-bit counter advances on falling read strobe
// - hold acknowledge blocks counting of dma cycles
// - mode input selects one or two taken cycles
// - stretch early-dropped status for three cycles
`timescale 1ns/1ns
`include "inta_takeover_consts.vh"

// two-flop synchroniser for backplane levels; the first flop may go
// metastable, so only the second one is ever read outside this module
module level_sync #(
    parameter WIDTH = 1
) (
    input  wire             CLK,
    input  wire             RST_B,
    input  wire [WIDTH-1:0] d_in,
    output wire [WIDTH-1:0] q_out
);

    reg [WIDTH-1:0] meta_reg;    // first stage, may settle late
    reg [WIDTH-1:0] stable_reg;  // second stage, safe to read

    // both stages clear to the idle level of the backplane lines
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            meta_reg   <= {WIDTH{1'b0}};
            stable_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg   <= d_in;
            stable_reg <= meta_reg;
        end
    end

    assign q_out = stable_reg;

endmodule // level_sync

module inta_bus_takeover (
    input  wire        CLK,
    input  wire        RST_B,
    input  wire        DBIN,
    input  wire        HLDA,
    input  wire        CPU_INTA,
    input  wire        THREE_BYTE_MODE,
    input  wire [2:0]  CASCADE_CODE,
    output reg         STATUS_DISABLE_B,
    output reg         INTA_OUT,
    output reg         INTA_OE,
    output reg         ADDR_OE,
    output reg  [2:0]  ADDR_LOW_OUT,
    output reg  [1:0]  CYCLE_COUNT
);

    wire              dbin_s;      // read strobe after two flops
    wire              hlda_s;      // hold acknowledge after two flops
    wire              inta_s;      // cpu acknowledge status after two flops
    wire              mode_s;      // mode strap after two flops
    reg               dbin_q_reg;
    reg [`HOLD_W-1:0] hold_reg;
    reg [2:0]         state_reg;
    reg [2:0]         state_next;
    reg [`CNT_W-1:0]  cnt_reg;
    reg [`CNT_W-1:0]  cnt_next;
    wire              strobe_fall;
    wire              inta_seen;
    wire              take_next;
    wire [`CNT_W-1:0] last_cnt;

    // backplane levels are asynchronous to CLK; each passes two flops
    level_sync #(.WIDTH(1)) u_dbin_sync (
        .CLK   (CLK),
        .RST_B (RST_B),
        .d_in  (DBIN),
        .q_out (dbin_s)
    );

    level_sync #(.WIDTH(1)) u_hlda_sync (
        .CLK   (CLK),
        .RST_B (RST_B),
        .d_in  (HLDA),
        .q_out (hlda_s)
    );

    level_sync #(.WIDTH(1)) u_inta_sync (
        .CLK   (CLK),
        .RST_B (RST_B),
        .d_in  (CPU_INTA),
        .q_out (inta_s)
    );

    // the strap is static, but it still sits on a backplane pin
    level_sync #(.WIDTH(1)) u_mode_sync (
        .CLK   (CLK),
        .RST_B (RST_B),
        .d_in  (THREE_BYTE_MODE),
        .q_out (mode_s)
    );

    // delayed strobe copy for the edge detect; clears low like the idle
    // strobe, so no false falling edge follows reset
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            dbin_q_reg <= 1'b0;
        end else begin
            dbin_q_reg <= dbin_s;
        end
    end

    // trailing strobe edge, ignored while dma holds the bus
    assign strobe_fall = dbin_q_reg & ~dbin_s & ~hlda_s;

    // hold status a few cycles since some cpu cards drop it early
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            hold_reg <= `HOLD_ZERO;
        end else if (inta_s) begin
            hold_reg <= `HOLD_LOAD;
        end else if (hold_reg != `HOLD_ZERO) begin
            hold_reg <= hold_reg - 1'b1;
        end
    end

    assign inta_seen = inta_s | (hold_reg != `HOLD_ZERO);
    assign last_cnt  = mode_s ? `CNT_TWO : `CNT_ONE;
    assign take_next = (state_next == `ST_TAKE);

    // timing of one takeover, in CLK edges after the strobe pin falls:
    //   second edge  the fall is visible past the synchronisers
    //   third edge   state, count and bus drivers switch together
    // idle waits for a first cycle with status present or still held;
    // each counted strobe fall then moves the taken-cycle count on, and
    // the fall that ends the last taken cycle hands both buses back
    // limitation: a strobe level shorter than one clock can be missed,
    // so the backplane strobe must stay high and low one clock or more

    // sequence: wait for first cycle, then own the bus for later ones
    always @* begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            `ST_IDLE: begin
                cnt_next = `CNT_ZERO;
                if (inta_seen & dbin_s) begin
                    state_next = `ST_FIRST;
                end
            end
            `ST_FIRST: begin
                if (strobe_fall) begin
                    state_next = `ST_TAKE;
                    cnt_next   = `CNT_ONE;
                end else if (!inta_seen && !dbin_s) begin
                    state_next = `ST_IDLE;
                end
            end
            `ST_TAKE: begin
                if (strobe_fall) begin
                    if (cnt_reg == last_cnt) begin
                        state_next = `ST_IDLE;
                        cnt_next   = `CNT_ZERO;
                    end else begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
            end
            default: begin
                state_next = `ST_IDLE;
                cnt_next   = `CNT_ZERO;
            end
        endcase
    end

    // state and counter registers
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg   <= `ST_IDLE;
            cnt_reg     <= `CNT_ZERO;
            CYCLE_COUNT <= `CNT_ZERO;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            CYCLE_COUNT <= cnt_next;
        end
    end

    // status bus takeover; fed from state_next so the pins move on the
    // same edge as the state rather than one cycle behind it
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            STATUS_DISABLE_B <= 1'b1;
            INTA_OUT         <= 1'b0;
            INTA_OE          <= 1'b0;
        end else begin
            STATUS_DISABLE_B <= ~take_next;
            INTA_OUT         <= take_next;
            INTA_OE          <= take_next;
        end
    end

    // address bus takeover with the cascade code on the low lines
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ADDR_OE      <= 1'b0;
            ADDR_LOW_OUT <= `CASC_ZERO;
        end else begin
            ADDR_OE      <= take_next;
            ADDR_LOW_OUT <= take_next ? CASCADE_CODE : `CASC_ZERO;
        end
    end

endmodule // inta_bus_takeover

// ### testbench/inta_takeover_chk_assertions.sv
// port checker for the takeover block
// one clock, async active-low reset
`timescale 1ns/1ns
module inta_takeover_chk(input wire logic CLK, RST_B, DBIN, HLDA, THREE_BYTE_MODE,
    STATUS_DISABLE_B, INTA_OUT, INTA_OE, ADDR_OE,
    input wire logic [2:0] CASCADE_CODE, ADDR_LOW_OUT, input wire logic [1:0] CYCLE_COUNT);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // a strobe fall during a dma grant
    sequence dma_fall; HLDA && $fell(DBIN); endsequence
    chk_status_own: assert property (STATUS_DISABLE_B != INTA_OE) else $error("own");
    chk_ack_high: assert property (INTA_OE |-> INTA_OUT) else $error("ack");
    chk_addr_own: assert property (ADDR_OE == INTA_OE) else $error("addr");
    chk_casc_code: assert property (ADDR_OE |-> ADDR_LOW_OUT == $past(CASCADE_CODE))
        else $error("code");
    chk_cnt_step: assert property (!HLDA && INTA_OE && $fell(DBIN) |-> ##[2:5]
        $changed(CYCLE_COUNT)) else $error("step");
    chk_dma_skip: assert property (dma_fall |-> $stable(CYCLE_COUNT)[*6])
        else $error("dma");
    chk_mode_one: assert property (!THREE_BYTE_MODE |-> CYCLE_COUNT != 2'h2)
        else $error("mode");
    chk_idle_rel: assert property ((CYCLE_COUNT != 2'h0) == INTA_OE) else $error("idle");
endmodule // inta_takeover_chk
bind inta_bus_takeover inta_takeover_chk u_chk (
    .CLK              (CLK),
    .RST_B            (RST_B),
    .DBIN             (DBIN),
    .HLDA             (HLDA),
    .THREE_BYTE_MODE  (THREE_BYTE_MODE),
    .STATUS_DISABLE_B (STATUS_DISABLE_B),
    .INTA_OUT         (INTA_OUT),
    .INTA_OE          (INTA_OE),
    .ADDR_OE          (ADDR_OE),
    .CASCADE_CODE     (CASCADE_CODE),
    .ADDR_LOW_OUT     (ADDR_LOW_OUT),
    .CYCLE_COUNT      (CYCLE_COUNT)
);

// ### testbench/cpu_card_model.sv
// cpu card model: strobe, ack status, hold ack
// status only on the first ack byte
`timescale 1ns/1ns
module cpu_card_model(input wire logic CLK, output logic DBIN = 0,
    output logic CPU_INTA = 0, output logic HLDA = 0);
    // one bus cycle; early drops status on the edge where the strobe rises
    task cyc(input logic st, early, hold);
        @(negedge CLK);
        HLDA = hold;
        CPU_INTA = st;
        if (early) @(negedge CLK);
        if (early) CPU_INTA = 0;
        DBIN = 1;
        repeat (4) @(negedge CLK);
        CPU_INTA = 0;
        DBIN = 0;
        repeat (5) @(negedge CLK);
        HLDA = 0;
    endtask
endmodule // cpu_card_model

// ### testbench/inta_bus_takeover_tb_top.sv
// bench for the takeover block
// cpu model drives strobes; cascade code fixed
`timescale 1ns/1ns
module inta_bus_takeover_tb_top;
    logic       CLK = 0, RST_B = 0, THREE_BYTE_MODE = 0;
    logic [2:0] CASCADE_CODE = 3'h5, ADDR_LOW_OUT;
    logic [1:0] CYCLE_COUNT;
    logic       DBIN, HLDA, CPU_INTA, STATUS_DISABLE_B, INTA_OUT, INTA_OE, ADDR_OE;
    int         failures = 0, n_checks = 0;
    initial forever #10 CLK = ~CLK;
    cpu_card_model cpu (
        .CLK      (CLK),
        .DBIN     (DBIN),
        .CPU_INTA (CPU_INTA),
        .HLDA     (HLDA)
    );
    inta_bus_takeover dut (
        .CLK              (CLK),
        .RST_B            (RST_B),
        .DBIN             (DBIN),
        .HLDA             (HLDA),
        .CPU_INTA         (CPU_INTA),
        .THREE_BYTE_MODE  (THREE_BYTE_MODE),
        .CASCADE_CODE     (CASCADE_CODE),
        .STATUS_DISABLE_B (STATUS_DISABLE_B),
        .INTA_OUT         (INTA_OUT),
        .INTA_OE          (INTA_OE),
        .ADDR_OE          (ADDR_OE),
        .ADDR_LOW_OUT     (ADDR_LOW_OUT),
        .CYCLE_COUNT      (CYCLE_COUNT)
    );
    task ck(input string name, input logic [8:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s exp %h seen %h", name, exp, seen);
        end
    endtask
    // one cycle, then outputs against the count expected
    task t(input logic st, early, hold, input logic [1:0] c);
        cpu.cyc(st, early, hold);
        ck("outputs", {ADDR_LOW_OUT, STATUS_DISABLE_B, INTA_OUT, INTA_OE, ADDR_OE,
            CYCLE_COUNT}, (c != 2'h0) ? {CASCADE_CODE, 4'h7, c} : 9'h020);
    endtask
    task s_one;
        THREE_BYTE_MODE = 0;
        t(1, 0, 0, 2'h1);
        t(0, 0, 0, 2'h0);
        $display("single byte done");
    endtask
    task s_three;
        THREE_BYTE_MODE = 1;
        t(1, 0, 0, 2'h1);
        t(0, 0, 1, 2'h1);
        t(0, 0, 0, 2'h2);
        t(0, 0, 0, 2'h0);
        $display("three byte done");
    endtask
    // early status drop, then reset mid-sequence
    task s_early;
        t(1, 1, 0, 2'h1);
        RST_B = 0;
        @(negedge CLK);
        ck("reset outputs", {ADDR_LOW_OUT, STATUS_DISABLE_B, INTA_OUT, INTA_OE, ADDR_OE,
            CYCLE_COUNT}, 9'h020);
        RST_B = 1;
        t(1, 0, 0, 2'h1);
        t(0, 0, 0, 2'h2);
        t(0, 0, 0, 2'h0);
        $display("early status done");
    endtask
    task print_verdict;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge CLK);
        RST_B = 1;
        s_one;
        s_three;
        s_early;
        print_verdict;
    end
    // watchdog well past the few microseconds of tests
    initial begin
        #20000;
        failures++;
        print_verdict;
    end
endmodule // inta_bus_takeover_tb_top
